// ---- inc/cwfc_regs.svh ----
/*
  constants of the can wake and fault control block: mode encodings,
  bit positions and timing counts.
  assumes a 20 MHz core clock.
*/
`ifndef CWFC_REGS_SVH
`define CWFC_REGS_SVH

// ----------------------------------------
// chip and transceiver mode encodings
// ----------------------------------------
`define CWFC_CHIP_NORMAL   3'h0
`define CWFC_CHIP_STOP     3'h1
`define CWFC_CHIP_SLEEP    3'h2
`define CWFC_CHIP_RESTART  3'h3
`define CWFC_CHIP_FAILSAFE 3'h4
`define CWFC_CAN_OFF       2'h0
`define CWFC_CAN_WAKE      2'h1
`define CWFC_CAN_RXONLY    2'h2
`define CWFC_CAN_NORMAL    2'h3

// ----------------------------------------
// wake source status bit position
// ----------------------------------------
`define CWFC_WK_BUS_BIT    0

// ----------------------------------------
// timing: microseconds and derived cycles at 20 MHz
// ----------------------------------------
`define CWFC_CLK_MHZ       20
`define CWFC_WAKE_US       1
`define CWFC_TXD_TO_US     4500
`define CWFC_BUS_TO_US     4500
`define CWFC_WAKE_CYC      (`CWFC_WAKE_US * `CWFC_CLK_MHZ)
`define CWFC_TXD_TO_CYC    (`CWFC_TXD_TO_US * `CWFC_CLK_MHZ)
`define CWFC_BUS_TO_CYC    (`CWFC_BUS_TO_US * `CWFC_CLK_MHZ)
`define CWFC_CNT_W         17

`endif

// ---- inc/cwfc_pkg.sv ----
/*
  types of the can wake and fault control block.
  assumes cwfc_regs.svh is on the include path.
*/
`default_nettype none
`include "cwfc_regs.svh"
package cwfc_pkg;

  // ----------------------------------------
  // mode fields and fault flags
  // ----------------------------------------
  typedef logic [2:0] cwfc_chip_mode_t;
  typedef logic [1:0] cwfc_can_mode_t;

  typedef struct packed {
    logic bus_wake_flag;
    logic can_fail;
    logic xcvr_supply_low_flag;
  } cwfc_status_t;

  typedef enum logic [1:0] {
    WK_IDLE,
    WK_DOM1,
    WK_REC,
    WK_DOM2
  } cwfc_wup_state_t;

endpackage
`default_nettype wire

// ---- rtl/cwfc_filter.sv ----
/*
  dominant time counter: counts cycles while its input holds, and flags
  when the count reaches the limit.
  assumes a synchronised input on the core clock.
*/
`default_nettype none
`include "cwfc_regs.svh"
module cwfc_filter #(
  parameter logic [`CWFC_CNT_W-1:0] LIMIT = `CWFC_CNT_W'h0_014
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  output logic      over_o
);
  import cwfc_pkg::*;

  typedef struct packed {
    logic [`CWFC_CNT_W-1:0] cnt;
    logic                   over;
  } cwfc_flt_t;

  cwfc_flt_t st;
  cwfc_flt_t next_st;

  // count up while level holds, saturate at the limit
  always_comb begin
    next_st = st;
    if (!level_i) begin
      next_st.cnt  = '0;
      next_st.over = 1'b0;
    end else if (st.cnt < LIMIT) begin
      next_st.cnt = st.cnt + `CWFC_CNT_W'h0_001;
    end else begin
      next_st.over = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign over_o = st.over;
endmodule
`default_nettype wire

// ---- rtl/cwfc_top.sv ----
/*
  can wake and fault control: bus wake detection and reporting per chip
  mode, watchdog re-enable, transmit and bus dominant time-outs and
  transceiver supply undervoltage monitoring.
  assumes pins arrive asynchronous; mode fields come from the spi block
  on the same clock.
*/
// How it works
// - stop-mode bus wake raises interrupt and records wake status
// - stop-mode bus wake also drives receive output low
// - normal-mode bus wake reports the same way
// - stop mode stays after wake; controller commands normal mode
// - stop-mode bus wake re-enables disabled watchdog if enable bit set
// - sleep-mode wake needs dominant phases longer than wake filter time
// - sleep wake goes to restart then normal, receive output low
// - sleep wake raises no interrupt
// - fail-safe wake goes to restart, regulator ramps, receive low
// - transmit dominant too long disables driver, receive only
// - transmit time-out sets failure flag
// - driver returns when transmit dominance ends; mode bits kept
// - bus dominant too long sets failure flag; mode bits kept
// - supply monitored only in can normal/rx-only and chip normal/stop
// - supply undervoltage sets flag and disables transmitter
// - supply recovery re-enables transmitter; mode bits kept
// - after wake mode field reads wake, receive stays low until changed
// - wake re-armed by mode toggle or entry to stop or fail-safe
`default_nettype none
`include "cwfc_regs.svh"
module cwfc_top #(
  parameter logic [`CWFC_CNT_W-1:0] TXD_TO_CYC = `CWFC_CNT_W'(`CWFC_TXD_TO_CYC),
  parameter logic [`CWFC_CNT_W-1:0] BUS_TO_CYC = `CWFC_CNT_W'(`CWFC_BUS_TO_CYC)
) (
  input  wire logic                      CORE_CLK_I,
  input  wire logic                      RST_I,
  input  wire cwfc_pkg::cwfc_chip_mode_t CHIP_MODE_I,
  input  wire cwfc_pkg::cwfc_can_mode_t  CAN_MODE_I,
  input  wire logic                      WATCHDOG_ON_BUS_WAKE_I,
  input  wire logic                      WATCHDOG_EN_I,
  input  wire logic                      BUS_DOMINANT_I,
  input  wire logic                      BUS_TRANSMIT_IN_I,
  input  wire logic                      XCVR_SUPPLY_LOW_I,
  input  wire logic                      STATUS_CLR_I,
  input  wire logic                      RESTART_DONE_I,
  output logic                           BUS_RECEIVE_OUT_O,
  output logic                           INT_N_O,
  output logic                           DRIVER_EN_O,
  output logic                           WATCHDOG_SET_O,
  output logic                           GO_RESTART_O,
  output logic                           GO_NORMAL_O,
  output logic                           REG_RAMP_O,
  output cwfc_pkg::cwfc_status_t         STATUS_O,
  output logic [7:0]                     WAKE_SOURCE_STATUS_O
);
  import cwfc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0]             bus_s;
    logic [1:0]             txd_s;
    logic [1:0]             uv_s;
    cwfc_can_mode_t         can_prev;
    cwfc_chip_mode_t        chip_prev;
    logic                   armed;
    logic                   woken;
    cwfc_wup_state_t        wup;
    logic [`CWFC_CNT_W-1:0] wcnt;
    logic                   in_restart;
    logic                   rxd;
    logic                   int_n;
    logic                   drv;
    logic                   wd_set;
    logic                   go_rst;
    logic                   go_nrm;
    logic                   ramp;
    cwfc_status_t           status;
  } cwfc_state_t;

  cwfc_state_t st;
  cwfc_state_t next_st;

  logic bus_dom;
  logic txd_dom;
  logic uv;
  logic txd_over;
  logic bus_over;
  logic in_wake_mode;
  logic monitor_uv;
  logic wake_evt;
  logic wake_over;

  // synchronised pin levels (second stage only)
  assign bus_dom = st.bus_s[1];
  assign txd_dom = ~st.txd_s[1];
  assign uv      = st.uv_s[1];

  // ----------------------------------------
  // dominant time-out counters
  // ----------------------------------------
  // transmit time-out only runs in can normal mode
  cwfc_filter #(.LIMIT(TXD_TO_CYC)) u_txd_to (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .level_i (txd_dom && CAN_MODE_I == `CWFC_CAN_NORMAL),
    .over_o  (txd_over)
  );

  // bus clamp counter in normal or receive only
  cwfc_filter #(.LIMIT(BUS_TO_CYC)) u_bus_to (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .level_i (bus_dom && (CAN_MODE_I == `CWFC_CAN_NORMAL ||
                          CAN_MODE_I == `CWFC_CAN_RXONLY)),
    .over_o  (bus_over)
  );

  // ----------------------------------------
  // mode decode helpers
  // ----------------------------------------
  function automatic logic is_chip(input cwfc_chip_mode_t m, input cwfc_chip_mode_t v);
    is_chip = (m == v);
  endfunction

  assign in_wake_mode = (CAN_MODE_I == `CWFC_CAN_WAKE) ||
                        is_chip(CHIP_MODE_I, `CWFC_CHIP_FAILSAFE);
  assign monitor_uv   = (CAN_MODE_I == `CWFC_CAN_NORMAL ||
                         CAN_MODE_I == `CWFC_CAN_RXONLY) &&
                        (is_chip(CHIP_MODE_I, `CWFC_CHIP_NORMAL) ||
                         is_chip(CHIP_MODE_I, `CWFC_CHIP_STOP));
  assign wake_over    = st.wcnt >= `CWFC_CNT_W'(`CWFC_WAKE_CYC);

  // wake pattern completes on the second qualified dominant phase
  assign wake_evt = st.wup == WK_DOM2 && bus_dom && wake_over &&
                    st.armed && in_wake_mode;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st           = st;
    next_st.bus_s     = {st.bus_s[0], BUS_DOMINANT_I};
    next_st.txd_s     = {st.txd_s[0], BUS_TRANSMIT_IN_I};
    next_st.uv_s      = {st.uv_s[0], XCVR_SUPPLY_LOW_I};
    next_st.can_prev  = CAN_MODE_I;
    next_st.chip_prev = CHIP_MODE_I;
    next_st.wd_set    = 1'b0;
    next_st.go_rst    = 1'b0;
    next_st.go_nrm    = 1'b0;

    // wake pattern filter: dominant, recessive, dominant, each > filter
    case (st.wup)
      WK_IDLE: begin
        next_st.wcnt = '0;
        if (bus_dom && st.armed && in_wake_mode) begin
          next_st.wup = WK_DOM1;
        end
      end
      WK_DOM1: begin
        if (bus_dom) begin
          next_st.wcnt = wake_over ? st.wcnt : st.wcnt + `CWFC_CNT_W'h0_001;
        end else begin
          next_st.wup  = wake_over ? WK_REC : WK_IDLE;
          next_st.wcnt = '0;
        end
      end
      WK_REC: begin
        if (!bus_dom) begin
          next_st.wcnt = wake_over ? st.wcnt : st.wcnt + `CWFC_CNT_W'h0_001;
        end else begin
          next_st.wup  = wake_over ? WK_DOM2 : WK_DOM1;
          next_st.wcnt = '0;
        end
      end
      WK_DOM2: begin
        if (wake_evt) begin
          next_st.wup = WK_IDLE;
        end else if (bus_dom) begin
          next_st.wcnt = st.wcnt + `CWFC_CNT_W'h0_001;
        end else begin
          next_st.wup  = WK_IDLE;
          next_st.wcnt = '0;
        end
      end
      default: begin
        next_st.wup = WK_IDLE;
      end
    endcase
    if (!in_wake_mode || !st.armed) begin
      next_st.wup = WK_IDLE;
    end

    // re-arm on toggle away from wake mode or entry to stop/fail-safe
    if (CAN_MODE_I != `CWFC_CAN_WAKE && !is_chip(CHIP_MODE_I, `CWFC_CHIP_FAILSAFE)) begin
      next_st.armed = 1'b1;
      next_st.woken = 1'b0;
    end
    if ((is_chip(CHIP_MODE_I, `CWFC_CHIP_STOP) &&
         !is_chip(st.chip_prev, `CWFC_CHIP_STOP)) ||
        (is_chip(CHIP_MODE_I, `CWFC_CHIP_FAILSAFE) &&
         !is_chip(st.chip_prev, `CWFC_CHIP_FAILSAFE))) begin
      next_st.armed = 1'b1;
    end

    // wake reaction per chip mode
    if (wake_evt) begin
      next_st.armed = 1'b0;
      next_st.woken = 1'b1;
      next_st.status.bus_wake_flag = 1'b1;
      case (CHIP_MODE_I)
        `CWFC_CHIP_NORMAL: begin
          next_st.int_n = 1'b0;
        end
        `CWFC_CHIP_STOP: begin
          // chip stays in stop; controller must command normal
          next_st.int_n = 1'b0;
          if (WATCHDOG_ON_BUS_WAKE_I && !WATCHDOG_EN_I) begin
            next_st.wd_set = 1'b1;
          end
        end
        `CWFC_CHIP_SLEEP, `CWFC_CHIP_FAILSAFE: begin
          next_st.go_rst     = 1'b1;
          next_st.ramp       = 1'b1;
          next_st.in_restart = 1'b1;
        end
        default: begin
          next_st.int_n = st.int_n;  // restart: stay, no interrupt
        end
      endcase
    end

    // restart finished: hand over to normal mode
    if (st.in_restart && RESTART_DONE_I) begin
      next_st.in_restart = 1'b0;
      next_st.ramp       = 1'b0;
      next_st.go_nrm     = 1'b1;
    end

    // interrupt released by status clear unless a new wake lands
    if (STATUS_CLR_I && !wake_evt) begin
      next_st.int_n                = 1'b1;
      next_st.status.bus_wake_flag = 1'b0;
    end
    if (STATUS_CLR_I && !txd_over && !bus_over) begin
      next_st.status.can_fail = 1'b0;
    end
    if (STATUS_CLR_I && !(monitor_uv && uv)) begin
      next_st.status.xcvr_supply_low_flag = 1'b0;
    end

    // failure flags: set wins over clear
    if (txd_over || bus_over) begin
      next_st.status.can_fail = 1'b1;
    end
    if (monitor_uv && uv) begin
      next_st.status.xcvr_supply_low_flag = 1'b1;
    end

    // receive output: low while woken, follows bus only when receiving
    next_st.rxd = 1'b1;
    if (CAN_MODE_I == `CWFC_CAN_NORMAL || CAN_MODE_I == `CWFC_CAN_RXONLY) begin
      next_st.rxd = ~bus_dom;
    end
    if (st.woken) begin
      next_st.rxd = 1'b0;
    end
    if (wake_evt) begin
      next_st.rxd = 1'b0;
    end

    // driver enabled only in normal mode with no transmit time-out or monitored supply undervoltage
    next_st.drv = (CAN_MODE_I == `CWFC_CAN_NORMAL) && !txd_over &&
                  !(monitor_uv && uv);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st       <= '0;
      st.int_n <= 1'b1;
      st.rxd   <= 1'b1;
      st.armed <= 1'b1;
      st.bus_s <= 2'h0;
      st.txd_s <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs straight from flip-flops
  // ----------------------------------------
  assign BUS_RECEIVE_OUT_O    = st.rxd;
  assign INT_N_O              = st.int_n;
  assign DRIVER_EN_O          = st.drv;
  assign WATCHDOG_SET_O       = st.wd_set;
  assign GO_RESTART_O         = st.go_rst;
  assign GO_NORMAL_O          = st.go_nrm;
  assign REG_RAMP_O           = st.ramp;
  assign STATUS_O             = st.status;
  assign WAKE_SOURCE_STATUS_O = {7'h00, st.status.bus_wake_flag};
endmodule
`default_nettype wire

// ---- verification/cwfc_partner.sv ----
/*
  far side model: bus wake pattern source, clamp and transmit pin.
  assumes one core clock; lengths in core cycles.
*/
`default_nettype none
module cwfc_partner (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] len_i,
  input  wire logic       tx_low_i,
  input  wire logic       clamp_i,
  output logic            bus_dom_o,
  output logic            txd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] cnt = 10'h000;
  // three phases: dominant, recessive, dominant of len_i each
  always_ff @(posedge clk_i) begin
    if (go_i) begin
      cnt <= 10'(len_i) * 10'h003;
    end else if (cnt != 10'h000) begin
      cnt <= cnt - 10'h001;
    end
  end
  // bus level high is dominant; transmit pin low is dominant
  assign bus_dom_o = clamp_i || (cnt != 10'h000
    && (cnt > {1'b0, len_i, 1'b0} || cnt <= {2'b00, len_i}));
  assign txd_o = !tx_low_i;
endmodule
`default_nettype wire

// ---- verification/cwfc_properties.sv ----
/*
  port checks of the can wake and fault control top.
  assumes bind into cwfc_top, one clock domain.
*/
`default_nettype none
`include "cwfc_regs.svh"
module cwfc_properties (
  input wire logic                      CORE_CLK_I,
  input wire logic                      RST_I,
  input wire cwfc_pkg::cwfc_chip_mode_t CHIP_MODE_I,
  input wire cwfc_pkg::cwfc_can_mode_t  CAN_MODE_I,
  input wire logic                      WATCHDOG_ON_BUS_WAKE_I,
  input wire logic                      WATCHDOG_EN_I,
  input wire logic                      STATUS_CLR_I,
  input wire logic                      RESTART_DONE_I,
  input wire logic                      BUS_RECEIVE_OUT_O,
  input wire logic                      INT_N_O,
  input wire logic                      DRIVER_EN_O,
  input wire logic                      WATCHDOG_SET_O,
  input wire logic                      GO_RESTART_O,
  input wire logic                      GO_NORMAL_O,
  input wire logic                      REG_RAMP_O,
  input wire cwfc_pkg::cwfc_status_t    STATUS_O,
  input wire logic [7:0]                WAKE_SOURCE_STATUS_O
);
  import cwfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);
  a_int_holds: assert property (
    !INT_N_O && !STATUS_CLR_I |=> !INT_N_O) else $error("interrupt released early");
  a_wake_report: assert property (
    $rose(STATUS_O.bus_wake_flag) && $past(CHIP_MODE_I) <= `CWFC_CHIP_STOP
    |-> !INT_N_O && !BUS_RECEIVE_OUT_O && WAKE_SOURCE_STATUS_O[`CWFC_WK_BUS_BIT])
    else $error("wake not reported");
  a_rxd_holds: assert property (
    !BUS_RECEIVE_OUT_O && CAN_MODE_I == `CWFC_CAN_WAKE |=> !BUS_RECEIVE_OUT_O)
    else $error("receive output released in wake mode");
  a_wdog_pulse: assert property (
    WATCHDOG_SET_O |-> ($past(CHIP_MODE_I) == `CWFC_CHIP_STOP
    && $past(WATCHDOG_ON_BUS_WAKE_I) && !$past(WATCHDOG_EN_I)) ##1 !WATCHDOG_SET_O)
    else $error("bad watchdog request");
  a_stop_stays: assert property (
    CHIP_MODE_I == `CWFC_CHIP_STOP && $past(CHIP_MODE_I) == `CWFC_CHIP_STOP
    |-> !GO_RESTART_O) else $error("restart requested in stop");
  a_sleep_quiet: assert property (
    GO_RESTART_O && $past(INT_N_O) |-> INT_N_O && REG_RAMP_O && !BUS_RECEIVE_OUT_O)
    else $error("restart wake reported wrongly");
  a_ramp_holds: assert property (
    REG_RAMP_O && !RESTART_DONE_I |=> REG_RAMP_O) else $error("ramp dropped early");
  a_normal_req: assert property (
    GO_NORMAL_O |-> $past(RESTART_DONE_I)) else $error("normal request without done");
  a_drv_fault: assert property (
    $fell(DRIVER_EN_O) && $past(CAN_MODE_I) == `CWFC_CAN_NORMAL
    && $past(CAN_MODE_I, 2) == `CWFC_CAN_NORMAL
    |-> STATUS_O.can_fail || STATUS_O.xcvr_supply_low_flag)
    else $error("driver off without fault");
  // main scenarios reached
  c_wdog: cover property (WATCHDOG_SET_O);
  c_restart: cover property (GO_RESTART_O ##[1:300] GO_NORMAL_O);
  c_txd: cover property ($fell(DRIVER_EN_O) ##[1:100] $rose(DRIVER_EN_O));
endmodule
bind cwfc_top cwfc_properties i_cwfc_properties (
  .CORE_CLK_I, .RST_I, .CHIP_MODE_I, .CAN_MODE_I, .WATCHDOG_ON_BUS_WAKE_I,
  .WATCHDOG_EN_I, .STATUS_CLR_I, .RESTART_DONE_I, .BUS_RECEIVE_OUT_O, .INT_N_O,
  .DRIVER_EN_O, .WATCHDOG_SET_O, .GO_RESTART_O, .GO_NORMAL_O, .REG_RAMP_O,
  .STATUS_O, .WAKE_SOURCE_STATUS_O
);
`default_nettype wire

// ---- verification/cwfc_top_bench.sv ----
/*
  bench of the can wake and fault control top: wake, time-out, supply.
  assumes cwfc_partner and the bound checker are compiled.
*/
`default_nettype none
`include "cwfc_regs.svh"
module cwfc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import cwfc_pkg::*;
  logic            clk = 1'b0, rst = 1'b1, wob = 1'b1, wden = 1'b0;
  logic            sclr = 1'b0, rdone = 1'b0, slow = 1'b0;
  logic            go = 1'b0, tx = 1'b0, clamp = 1'b0;
  logic [7:0]      len = 8'h19;
  cwfc_chip_mode_t chip = `CWFC_CHIP_NORMAL;
  cwfc_can_mode_t  can = `CWFC_CAN_OFF;
  logic            bdom, txd, rxd, int_n, drv, wds, gor, gon, ramp;
  cwfc_status_t    st;
  logic [7:0]      wss;
  int              fails = 0, cmp_count = 0, n_wd = 0, n_rs = 0, n_nm = 0;
  // ----------------------------------------
  // clock, parts and pulse counters
  // ----------------------------------------
  always #25 clk = ~clk;
  cwfc_partner i_cwfc_partner (.clk_i(clk), .go_i(go), .len_i(len), .tx_low_i(tx),
    .clamp_i(clamp), .bus_dom_o(bdom), .txd_o(txd));
  cwfc_top #(.TXD_TO_CYC(17'h0_0032), .BUS_TO_CYC(17'h0_0032)) i_cwfc_top (
    .CORE_CLK_I(clk), .RST_I(rst), .CHIP_MODE_I(chip), .CAN_MODE_I(can),
    .WATCHDOG_ON_BUS_WAKE_I(wob), .WATCHDOG_EN_I(wden), .BUS_DOMINANT_I(bdom),
    .BUS_TRANSMIT_IN_I(txd), .XCVR_SUPPLY_LOW_I(slow), .STATUS_CLR_I(sclr),
    .RESTART_DONE_I(rdone), .BUS_RECEIVE_OUT_O(rxd), .INT_N_O(int_n),
    .DRIVER_EN_O(drv), .WATCHDOG_SET_O(wds), .GO_RESTART_O(gor), .GO_NORMAL_O(gon),
    .REG_RAMP_O(ramp), .STATUS_O(st), .WAKE_SOURCE_STATUS_O(wss));
  // pulses counted once per cycle
  always @(posedge clk) begin
    n_wd += (wds === 1'b1);
    n_rs += (gor === 1'b1);
    n_nm += (gon === 1'b1);
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    #1;
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task setm(input cwfc_chip_mode_t c, input cwfc_can_mode_t m);
    @(posedge clk);
    chip <= c;
    can <= m;
    tick(3);
  endtask
  task wup(input logic [7:0] l);
    @(posedge clk);
    len <= l;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    tick(3 * l + 6);
  endtask
  task clr(input logic done);
    @(posedge clk);
    sclr <= !done;
    rdone <= done;
    @(posedge clk);
    sclr <= 1'b0;
    rdone <= 1'b0;
    tick(3);
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    tick(20);
    chk({6'h00, rxd, int_n}, 8'h03);
    rst <= 1'b0;
    setm(`CWFC_CHIP_NORMAL, `CWFC_CAN_WAKE);
    wup(8'h19);
    chk({6'h00, rxd, int_n}, 8'h00);
    chk({5'h00, st}, 8'h04);
    chk(wss, 8'h01);
    clr(1'b0);
    wup(8'h19);
    chk({7'h00, int_n}, 8'h01);
    setm(`CWFC_CHIP_NORMAL, `CWFC_CAN_NORMAL);
    chk({7'h00, rxd}, 8'h01);
    setm(`CWFC_CHIP_STOP, `CWFC_CAN_WAKE);
    wup(8'h19);
    chk({6'h00, rxd, int_n}, 8'h00);
    chk(8'(n_wd), 8'h01);
    chk(8'(n_rs), 8'h00);
    clr(1'b0);
    setm(`CWFC_CHIP_SLEEP, `CWFC_CAN_OFF);
    setm(`CWFC_CHIP_SLEEP, `CWFC_CAN_WAKE);
    wup(8'h0a);
    chk({5'h00, st}, 8'h00);
    wup(8'h19);
    chk({5'h00, ramp, rxd, int_n}, 8'h05);
    chk(8'(n_rs), 8'h01);
    clr(1'b1);
    chk({3'h0, 4'(n_nm), ramp}, 8'h02);
    clr(1'b0);
    setm(`CWFC_CHIP_FAILSAFE, `CWFC_CAN_WAKE);
    wup(8'h19);
    chk({5'h00, ramp, rxd, int_n}, 8'h05);
    chk(8'(n_rs), 8'h02);
    clr(1'b1);
    clr(1'b0);
    setm(`CWFC_CHIP_NORMAL, `CWFC_CAN_NORMAL);
    chk({7'h00, drv}, 8'h01);
    tx <= 1'b1;
    tick(60);
    chk({4'h0, st, drv}, 8'h04);
    tx <= 1'b0;
    tick(6);
    chk({7'h00, drv}, 8'h01);
    clr(1'b0);
    setm(`CWFC_CHIP_NORMAL, `CWFC_CAN_RXONLY);
    clamp <= 1'b1;
    tick(60);
    chk({5'h00, st}, 8'h02);
    clamp <= 1'b0;
    tick(4);
    clr(1'b0);
    setm(`CWFC_CHIP_NORMAL, `CWFC_CAN_NORMAL);
    slow <= 1'b1;
    tick(6);
    chk({4'h0, st, drv}, 8'h02);
    slow <= 1'b0;
    tick(6);
    chk({7'h00, drv}, 8'h01);
    clr(1'b0);
    setm(`CWFC_CHIP_SLEEP, `CWFC_CAN_RXONLY);
    slow <= 1'b1;
    tick(6);
    chk({5'h00, st}, 8'h00);
    end_sim;
  end
  // watchdog against a hang
  initial begin
    tick(20000);
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire
